// ==== hw/fwm_defines.svh ====
// constants for the fault and warning manager
`ifndef FWM_DEFINES_SVH
`define FWM_DEFINES_SVH
`define CLK_HZ 250000000
`define ROTATE_MS 2000
`define TONE_STEP_MS 400
`define TONE_LO_HZ 500
`define TONE_HI_HZ 1200
`define SYS_LO 7'h0a
`define SYS_HI 7'h13
`define HW_LO 7'h01
`define HW_HI 7'h3d
`define APP_LO 7'h47
`define APP_HI 7'h51
`define SW_LO 7'h54
`define SW_HI 7'h5d
`define VALVE_N 8
`define BYPASS_IDX 2
`define EXHAUST_IDX 0
`define LOG_DEPTH 64
`endif

// ==== hw/fwm_pkg.sv ====
// types shared by the fault and warning manager
package fwm_pkg;
    typedef enum logic [1:0] {
        GRP_NONE = 2'h0,
        GRP_HW = 2'h1,
        GRP_APP = 2'h2,
        GRP_SW = 2'h3
    } grp_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_ERR = 3'h2,
        ST_SYS = 3'h4
    } state_t;
    typedef struct packed {
        logic valid;
        logic raise;
        logic is_err;
        logic hand;
        logic emis_off;
        logic fallback;
        logic [6:0] num;
    } ev_t;
    typedef struct packed {
        logic show;
        logic is_err;
        logic [3:0] tens;
        logic [3:0] ones;
        grp_t grp;
    } disp_t;
    typedef struct packed {
        logic is_err;
        logic [6:0] num;
    } log_entry_t;
endpackage

// ==== hw/fault_log.sv ====
// service log of messages in order of arrival
`timescale 1ns/1ps
`include "fwm_defines.svh"
module fault_log import fwm_pkg::*; #(
    parameter int DEPTH = `LOG_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic we,
    input log_entry_t wdata,
    input wire logic [AW-1:0] raddr,
    output log_entry_t rdata,
    output logic [AW:0] count
);
    log_entry_t mem [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] ridx;

    // read index 0 is the oldest kept entry; when full the oldest is lost
    assign ridx = wptr_q - count[AW-1:0] + raddr;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wptr_q] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wptr_q <= '0;
            count <= '0;
        end else if (we) begin
            wptr_q <= wptr_q + 1'b1;
            if (count != (AW+1)'(DEPTH)) begin
                count <= count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[ridx];
        end
    end
endmodule

// ==== hw/fault_warning_manager.sv ====
// fault supervision: error state, warnings, alarm outputs and log
`timescale 1ns/1ps
`include "fwm_defines.svh"
module fault_warning_manager import fwm_pkg::*; #(
    parameter int ROT_CYC = `CLK_HZ / 1000 * `ROTATE_MS,
    parameter int STEP_CYC = `CLK_HZ / 1000 * `TONE_STEP_MS,
    parameter int LO_CYC = `CLK_HZ / (2 * `TONE_LO_HZ),
    parameter int HI_CYC = `CLK_HZ / (2 * `TONE_HI_HZ),
    parameter int VALVES = `VALVE_N,
    parameter int LOG_DEPTH = `LOG_DEPTH,
    parameter int LAW = $clog2(LOG_DEPTH)
) (
    input wire logic clk,
    input wire logic srst,
    input ev_t ev,
    input wire logic clear_key,
    input wire logic ext_ack,
    input wire logic start_key,
    input wire logic stop_key,
    input wire logic wdt_fire,
    input wire logic [VALVES-1:0] valve_req,
    input wire logic [11:0] rec_in1,
    input wire logic [11:0] rec_in2,
    input wire logic [LAW-1:0] log_addr,
    output log_entry_t log_data,
    output logic [LAW:0] log_count,
    output logic fault_q,
    output logic sys_fault_q,
    output logic standby_req_q,
    output logic start_cmd_q,
    output logic stop_cmd_q,
    output logic lamp_force_q,
    output logic lamp_on_q,
    output logic hand_code_en_q,
    output logic [3:0] hand_tens_q,
    output logic [3:0] hand_ones_q,
    output logic trig_off_q,
    output disp_t disp_q,
    output logic tone_q,
    output logic [11:0] rec_out1_q,
    output logic [11:0] rec_out2_q,
    output logic [VALVES-1:0] valve_q,
    output logic emis_off_q
);
    localparam logic [VALVES-1:0] BYP = VALVES'(1) << `BYPASS_IDX;
    localparam logic [VALVES-1:0] EXH = VALVES'(1) << `EXHAUST_IDX;

    function automatic grp_t grp_of(input logic [6:0] n);
        if (n >= `HW_LO && n <= `HW_HI) begin
            return GRP_HW;
        end else if (n >= `APP_LO && n <= `APP_HI) begin
            return GRP_APP;
        end else if (n >= `SW_LO && n <= `SW_HI) begin
            return GRP_SW;
        end
        return GRP_NONE;
    endfunction

    function automatic disp_t code_of(input logic e, input logic [6:0] n);
        disp_t d;
        d.show = 1'b1;
        d.is_err = e;
        d.tens = 4'(n / 7'd10);
        d.ones = 4'(n % 7'd10);
        d.grp = grp_of(n);
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [4:0] pin_a_q;
    logic [4:0] pin_s_q;
    logic [4:0] pin_p_q;
    logic [4:0] rise;
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_a_q <= '0;
            pin_s_q <= '0;
            pin_p_q <= '0;
        end else begin
            pin_a_q <= {wdt_fire, stop_key, start_key, ext_ack, clear_key};
            pin_s_q <= pin_a_q;
            pin_p_q <= pin_s_q;
        end
    end
    assign rise = pin_s_q & ~pin_p_q;

    logic ack;
    logic wdt;
    assign ack = rise[0] | rise[1];
    assign wdt = rise[4];

    ////////////////////////////////////////////////////////////////////
    // error and warning bookkeeping
    logic [127:0] cause_q;
    logic [127:0] latch_q;
    logic [127:0] hand_q;
    logic [127:0] emis_q;
    logic warn_q;
    logic [6:0] warn_num_q;
    logic err_raise;
    logic warn_raise;
    logic sys_num;
    logic err_ok;
    state_t state_q;

    assign err_raise = ev.valid & ev.raise & ev.is_err;
    assign warn_raise = ev.valid & ev.raise & ~ev.is_err;
    assign sys_num = ev.num >= `SYS_LO && ev.num <= `SYS_HI;
    assign err_ok = state_q == ST_ERR && ack && cause_q == '0;

    always_ff @(posedge clk) begin
        if (srst || wdt) begin
            cause_q <= '0;
        end else if (ev.valid && ev.is_err) begin
            cause_q[ev.num] <= ev.raise;
        end
    end

    // a raise in the acknowledge cycle survives the clear
    always_ff @(posedge clk) begin
        if (srst || wdt) begin
            latch_q <= '0;
            hand_q <= '0;
            emis_q <= '0;
        end else begin
            if (err_ok) begin
                latch_q <= '0;
                hand_q <= '0;
                emis_q <= '0;
            end
            if (err_raise) begin
                latch_q[ev.num] <= 1'b1;
                hand_q[ev.num] <= ev.hand;
                emis_q[ev.num] <= ev.emis_off;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst || wdt) begin
            warn_q <= 1'b0;
            warn_num_q <= '0;
        end else if (warn_raise) begin
            warn_q <= 1'b1;
            warn_num_q <= ev.num;
        end else if (ack && state_q == ST_RUN) begin
            warn_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state: warnings never leave run
    always_ff @(posedge clk) begin
        if (srst || wdt) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (err_raise && sys_num) begin
                        state_q <= ST_SYS;
                    end else if (err_raise) begin
                        state_q <= ST_ERR;
                    end
                end
                ST_ERR: begin
                    if (err_raise && sys_num) begin
                        state_q <= ST_SYS;
                    end else if (err_ok && !err_raise) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_SYS: state_q <= ST_SYS; // only a restart leaves
                default: state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            standby_req_q <= 1'b0;
        end else begin
            standby_req_q <= wdt || (err_ok && !err_raise) ||
                (warn_raise && ev.fallback);
        end
    end

    logic log_we;
    log_entry_t log_wd;
    assign log_we = warn_raise || (err_raise && !sys_num);
    assign log_wd = '{is_err: ev.is_err, num: ev.num};

    fault_log #(.DEPTH(LOG_DEPTH), .AW(LAW)) u_log (
        .clk(clk),
        .srst(srst),
        .we(log_we),
        .wdata(log_wd),
        .raddr(log_addr),
        .rdata(log_data),
        .count(log_count)
    );

    ////////////////////////////////////////////////////////////////////
    // display rotation through latched errors
    logic [6:0] ptr_q;
    logic [31:0] rot_q;
    logic in_fault;
    disp_t cur_code;
    assign in_fault = state_q != ST_RUN;
    assign cur_code = code_of(1'b1, ptr_q);

    // empty slots are skipped one per cycle, far below the hold time
    always_ff @(posedge clk) begin
        if (srst) begin
            ptr_q <= '0;
            rot_q <= '0;
        end else if (!in_fault || !latch_q[ptr_q]) begin
            rot_q <= '0;
            if (in_fault) begin
                ptr_q <= ptr_q + 7'h1;
            end
        end else if (rot_q == 32'(ROT_CYC - 1)) begin
            rot_q <= '0;
            ptr_q <= ptr_q + 7'h1;
        end else begin
            rot_q <= rot_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            disp_q <= '0;
            hand_code_en_q <= 1'b0;
            hand_tens_q <= '0;
            hand_ones_q <= '0;
        end else if (in_fault) begin
            if (latch_q[ptr_q]) begin
                disp_q <= cur_code;
                hand_code_en_q <= hand_q[ptr_q];
                hand_tens_q <= cur_code.tens;
                hand_ones_q <= cur_code.ones;
            end
        end else begin
            hand_code_en_q <= 1'b0;
            disp_q <= warn_q ? code_of(1'b0, warn_num_q) : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarm tone and lamp blink share the 400 ms step
    logic [31:0] step_q;
    logic [31:0] half_q;
    logic hi_q;
    always_ff @(posedge clk) begin
        if (srst || !in_fault) begin
            step_q <= '0;
            hi_q <= 1'b0;
        end else if (step_q == 32'(STEP_CYC - 1)) begin
            step_q <= '0;
            hi_q <= !hi_q;
        end else begin
            step_q <= step_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !in_fault) begin
            half_q <= '0;
            tone_q <= 1'b0;
        end else if (half_q >= 32'((hi_q ? HI_CYC : LO_CYC) - 1)) begin
            half_q <= '0;
            tone_q <= !tone_q;
        end else begin
            half_q <= half_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs forced by the fault
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_q <= 1'b0;
            sys_fault_q <= 1'b0;
            lamp_force_q <= 1'b0;
            lamp_on_q <= 1'b0;
            trig_off_q <= 1'b0;
            rec_out1_q <= '0;
            rec_out2_q <= '0;
            valve_q <= '0;
            emis_off_q <= 1'b0;
        end else begin
            fault_q <= in_fault;
            sys_fault_q <= state_q == ST_SYS;
            lamp_force_q <= in_fault;
            lamp_on_q <= in_fault && !hi_q;
            trig_off_q <= in_fault;
            rec_out1_q <= in_fault ? 12'h000 : rec_in1;
            rec_out2_q <= in_fault ? 12'h000 : rec_in2;
            valve_q <= in_fault ? (valve_req & EXH) | BYP
                : valve_req;
            emis_off_q <= in_fault && |(latch_q & emis_q);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            start_cmd_q <= 1'b0;
            stop_cmd_q <= 1'b0;
        end else begin
            start_cmd_q <= rise[2] && !in_fault;
            stop_cmd_q <= rise[3] && !in_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////
    warn_stays_a: assert property (@(posedge clk) disable iff (srst)
        (warn_raise && state_q == ST_RUN && !wdt) |=> state_q == ST_RUN)
        else $error("warning moved the state");
    err_enter_a: assert property (@(posedge clk) disable iff (srst)
        (err_raise && !wdt) |=> state_q != ST_RUN)
        else $error("error did not enter fault");
    ack_gate_a: assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_ERR && cause_q != '0 && !wdt) |=> state_q != ST_RUN)
        else $error("error left while cause present");
    sys_hold_a: assert property (@(posedge clk) disable iff (srst)
        (state_q == ST_SYS && !wdt) |=> state_q == ST_SYS)
        else $error("system error left without restart");
    keys_block_a: assert property (@(posedge clk) disable iff (srst)
        in_fault |=> !start_cmd_q && !stop_cmd_q)
        else $error("key passed during fault");
    valve_safe_a: assert property (@(posedge clk) disable iff (srst)
        in_fault |=> valve_q[`BYPASS_IDX] && (valve_q & ~(BYP | EXH)) == '0)
        else $error("unsafe valve pattern");
    rec_zero_a: assert property (@(posedge clk) disable iff (srst)
        fault_q |-> rec_out1_q == 12'h000 && rec_out2_q == 12'h000)
        else $error("recorder not zero in fault");
    tone_step_a: assert property (@(posedge clk) disable iff (srst)
        (in_fault && step_q != 32'(STEP_CYC - 1)) |=> hi_q == $past(hi_q))
        else $error("tone changed early");
    rot_hold_a: assert property (@(posedge clk) disable iff (srst)
        (in_fault && latch_q[ptr_q] && rot_q != 32'(ROT_CYC - 1))
        |=> ptr_q == $past(ptr_q))
        else $error("display rotated early");
    no_syslog_a: assert property (@(posedge clk) disable iff (srst)
        (err_raise && sys_num) |=> log_count == $past(log_count))
        else $error("system error logged");
endmodule

// ==== verif/panel_model.sv ====
// behavioural operator panel, hand unit keys and control input
`timescale 1ns/1ps
module panel_model (
    input wire logic clk,
    input wire logic press,
    input wire logic [1:0] sel,
    output logic clear_key,
    output logic ext_ack,
    output logic start_key,
    output logic stop_key,
    output logic busy
);
    logic [3:0] keys_q;
    logic [2:0] cnt_q;
    assign clear_key = keys_q[0];
    assign ext_ack = keys_q[1];
    assign start_key = keys_q[2];
    assign stop_key = keys_q[3];
    assign busy = (cnt_q != 3'h0);
    initial begin
        keys_q = 4'h0;
        cnt_q = 3'h0;
    end
    // held two cycles, then low two, so every press is a fresh edge
    always @(posedge clk) begin
        if (press && cnt_q == 3'h0) begin
            keys_q <= 4'h1 << sel;
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h3) keys_q <= 4'h0;
        end
    end
endmodule

// ==== verif/fault_warning_manager_test.sv ====
// self-checking bench for the fault and warning manager
`timescale 1ns/1ps
module fault_warning_manager_test import fwm_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b1;
    ev_t ev = '0;
    logic clear_key, ext_ack, start_key, stop_key, kbusy;
    logic press = 1'b0;
    logic [1:0] sel = 2'h0;
    logic wdt_fire = 1'b0;
    logic [7:0] valve_req = 8'hfa;
    logic [11:0] rec_in1 = 12'h5a5;
    logic [11:0] rec_in2 = 12'h3c3;
    logic [2:0] log_addr = 3'h0;
    log_entry_t log_data;
    logic [3:0] log_count;
    logic fault_q, sys_fault_q, standby_req_q, start_cmd_q, stop_cmd_q;
    logic lamp_force_q, lamp_on_q, hand_code_en_q, trig_off_q, tone_q;
    logic emis_off_q;
    logic [3:0] hand_tens_q, hand_ones_q;
    disp_t disp_q;
    logic [11:0] rec_out1_q, rec_out2_q;
    logic [7:0] valve_q;
    int err_count = 0;
    int compares = 0;
    int stby_n = 0;
    int start_n = 0;
    always #2 clk = ~clk;
    // pulses last one cycle, so they are tallied rather than timed
    always @(posedge clk) begin
        if (standby_req_q === 1'b1) stby_n++;
        if (start_cmd_q === 1'b1) start_n++;
    end
    panel_model panel (.clk(clk), .press(press), .sel(sel),
        .clear_key(clear_key), .ext_ack(ext_ack), .start_key(start_key),
        .stop_key(stop_key), .busy(kbusy));
    fault_warning_manager #(.ROT_CYC(40), .STEP_CYC(20), .LO_CYC(6),
        .HI_CYC(3), .LOG_DEPTH(8)) dut (
        .clk(clk), .srst(srst), .ev(ev), .clear_key(clear_key),
        .ext_ack(ext_ack), .start_key(start_key), .stop_key(stop_key),
        .wdt_fire(wdt_fire), .valve_req(valve_req), .rec_in1(rec_in1),
        .rec_in2(rec_in2), .log_addr(log_addr), .log_data(log_data),
        .log_count(log_count), .fault_q(fault_q),
        .sys_fault_q(sys_fault_q), .standby_req_q(standby_req_q),
        .start_cmd_q(start_cmd_q), .stop_cmd_q(stop_cmd_q),
        .lamp_force_q(lamp_force_q), .lamp_on_q(lamp_on_q),
        .hand_code_en_q(hand_code_en_q), .hand_tens_q(hand_tens_q),
        .hand_ones_q(hand_ones_q), .trig_off_q(trig_off_q),
        .disp_q(disp_q), .tone_q(tone_q), .rec_out1_q(rec_out1_q),
        .rec_out2_q(rec_out2_q), .valve_q(valve_q),
        .emis_off_q(emis_off_q));
    ////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // flags in order valid, raise, is_err, hand, emis_off, fallback
    task send(input logic [5:0] f, input logic [6:0] num);
        @(posedge clk);
        #1 ev = {f, num};
    endtask
    task idle();
        cyc(1);
        ev = '0;
        cyc(3);
    endtask
    task key(input logic [1:0] s);
        int i;
        cyc(1);
        press = 1'b1;
        sel = s;
        cyc(1);
        press = 1'b0;
        for (i = 0; i < 20 && kbusy === 1'b1; i++) cyc(1);
        if (kbusy !== 1'b0) begin
            chk("key release", 0, kbusy);
            print_verdict();
        end
        cyc(4);
    endtask
    // the display walks empty slots first, so wait for the wanted code
    task wait_disp(input int n);
        int i;
        for (i = 0; i < 300; i++) begin
            if (disp_q.is_err === 1'b1 && disp_q.tens * 10 + disp_q.ones == n)
                break;
            cyc(1);
        end
        if (i == 300) begin
            chk("disp wait", n, disp_q.tens * 10 + disp_q.ones);
            print_verdict();
        end
    endtask
    task rd_log(input logic [2:0] a, input logic [7:0] exp);
        cyc(1);
        log_addr = a;
        cyc(2);
        chk("log entry", exp, log_data);
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_warning();
        int s0;
        s0 = stby_n;
        send(6'h31, 7'h2d);
        idle();
        chk("warn standby", s0 + 1, stby_n);
        chk("warn fault", 0, fault_q);
        chk("warn disp", {1'b1, 1'b0, 8'h45, GRP_HW}, disp_q);
        chk("warn log count", 1, log_count);
        rd_log(3'h0, {1'b0, 7'h2d});
        chk("valves normal", 8'hfa, valve_q);
        chk("rec normal", 12'h5a5, rec_out1_q);
        rec_in1 = 12'h123;
        rec_in2 = 12'h456;
        valve_req = 8'hfb;
        cyc(2);
        chk("rec1 pass", 12'h123, rec_out1_q);
        chk("rec2 pass", 12'h456, rec_out2_q);
        chk("valves pass", 8'hfb, valve_q);
        key(2'h2);
        chk("start outside fault", 1, start_n);
        key(2'h0);
        chk("warn cleared", 0, disp_q.show);
    endtask
    task t_error();
        int s0;
        send(6'h30, 7'h21);
        idle();
        chk("warn keeps run", 0, fault_q);
        send(6'h38, 7'h20);
        idle();
        chk("err fault", 1, fault_q);
        wait_disp(32);
        chk("err disp", {1'b1, 1'b1, 8'h32, GRP_HW}, disp_q);
        chk("trig off", 1, trig_off_q);
        chk("lamps forced", 1, lamp_force_q);
        chk("rec1 zero", 0, rec_out1_q);
        chk("rec2 zero", 0, rec_out2_q);
        chk("valves", 8'h05, valve_q);
        rd_log(3'h2, {1'b1, 7'h20});
        key(2'h2);
        chk("start ignored", 1, start_n);
        key(2'h0);
        chk("ack refused", 1, fault_q);
        send(6'h28, 7'h20);
        idle();
        s0 = stby_n;
        key(2'h1);
        chk("ack accepted", 0, fault_q);
        chk("ack standby", s0 + 1, stby_n);
    endtask
    task t_rotate();
        int i, c0, s0, last, hold, minh, seen71, seen88, t6, t3, lt;
        int tlen;
        logic pt, pl;
        c0 = log_count;
        send(6'h3e, 7'h47);
        send(6'h38, 7'h58);
        idle();
        chk("two logged", c0 + 2, log_count);
        wait_disp(71);
        chk("hand code", 1, hand_code_en_q);
        chk("hand digits", 8'h71, {hand_tens_q, hand_ones_q});
        chk("emission off", 1, emis_off_q);
        last = -1;
        hold = 0;
        minh = 1000;
        seen71 = 0;
        seen88 = 0;
        t6 = 0;
        t3 = 0;
        lt = 0;
        tlen = 0;
        pt = tone_q;
        pl = lamp_on_q;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            hold++;
            tlen++;
            if (disp_q.tens * 10 + disp_q.ones != last) begin
                if (last != -1 && seen71 + seen88 > 1 && hold < minh)
                    minh = hold;
                last = disp_q.tens * 10 + disp_q.ones;
                if (last == 71) seen71++;
                if (last == 88) seen88++;
                hold = 0;
            end
            if (tone_q !== pt) begin
                if (tlen == 6) t6++;
                if (tlen == 3) t3++;
                tlen = 0;
            end
            if (lamp_on_q !== pl) lt++;
            pt = tone_q;
            pl = lamp_on_q;
        end
        chk("rotate both", 1, seen71 > 1 && seen88 > 1);
        chk("rotate hold", 1, minh >= 40);
        chk("tone low", 1, t6 > 0);
        chk("tone high", 1, t3 > 0);
        chk("lamps blink", 1, lt >= 4);
        s0 = stby_n;
        c0 = log_count;
        cyc(1);
        wdt_fire = 1'b1;
        cyc(2);
        wdt_fire = 1'b0;
        cyc(5);
        chk("wdt standby", s0 + 1, stby_n);
        chk("wdt fault", 0, fault_q);
        chk("wdt no message", 0, disp_q.show);
        chk("wdt keeps log", c0, log_count);
    endtask
    task t_system();
        int c0;
        c0 = log_count;
        send(6'h38, 7'h0f);
        idle();
        chk("sys fault", 1, sys_fault_q);
        chk("sys not logged", c0, log_count);
        key(2'h0);
        key(2'h2);
        chk("sys ack refused", 1, sys_fault_q);
        chk("sys start refused", 1, start_n);
        cyc(1);
        wdt_fire = 1'b1;
        cyc(2);
        wdt_fire = 1'b0;
        cyc(5);
        chk("sys left", 0, sys_fault_q);
    endtask
    task print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(4);
        srst = 1'b0;
        cyc(3);
        t_warning();
        t_error();
        t_rotate();
        t_system();
        print_verdict();
    end
endmodule
